// >>> design/stmr_pkg.sv
/*
  constants, field layouts and carrier types of the standard timer.
  assumes an apb master on pclk and a byte wide register map, one word each.
*/
package stmr_pkg;

  // ****************************
  // register byte addresses
  // ****************************
  localparam logic [7:0] STMR_CTRL0_ADDR  = 8'h00;
  localparam logic [7:0] STMR_CTRL1_ADDR  = 8'h04;
  localparam logic [7:0] STMR_CNTL_ADDR   = 8'h08;
  localparam logic [7:0] STMR_CNTH_ADDR   = 8'h0c;
  localparam logic [7:0] STMR_CMPAL_ADDR  = 8'h10;
  localparam logic [7:0] STMR_CMPAH_ADDR  = 8'h14;
  localparam logic [7:0] STMR_CMPP_ADDR   = 8'h18;
  localparam logic [7:0] STMR_INSRC_ADDR  = 8'h1c;
  localparam logic [7:0] STMR_CAPL_ADDR   = 8'h20;
  localparam logic [7:0] STMR_CAPH_ADDR   = 8'h24;
  localparam logic [7:0] STMR_STAT_ADDR   = 8'h28;

  // ****************************
  // field positions and resets
  // ****************************
  localparam int STMR_PAUSE_BIT   = 7;
  localparam int STMR_CLKSEL_LSB  = 4;
  localparam int STMR_ON_BIT      = 3;
  localparam int STMR_MODE_LSB    = 6;
  localparam int STMR_PINF_LSB    = 4;
  localparam int STMR_INIT_BIT    = 3;
  localparam int STMR_CLRSRC_BIT  = 0;
  localparam logic [7:0] STMR_CTRL_RESET = 8'h00;
  localparam logic [7:0] STMR_BYTE_RESET = 8'h00;

  // ****************************
  // clock source divides
  // ****************************
  localparam int STMR_DIV_SYS4 = 4;
  localparam int STMR_DIV_H16  = 16;
  localparam int STMR_DIV_H64  = 64;
  localparam logic [5:0] STMR_PRE_RESET = 6'h00;

  typedef enum logic [1:0] {
    STMR_M_CMP  = 2'h0,
    STMR_M_CAP  = 2'h1,
    STMR_M_PWM  = 2'h2,
    STMR_M_TMR  = 2'h3
  } stmr_mode_t;

  typedef struct packed {
    logic       pause_ctl;
    logic [2:0] clk_sel;
    logic       counter_on;
    logic [2:0] period_cmp_field;
  } stmr_ctrl0_t;

  typedef struct packed {
    logic [1:0] op_mode_sel;
    logic [1:0] pin_func_sel;
    logic       out_initial_level;
    logic       out_polarity;
    logic       duty_period_swap;
    logic       clear_src_sel;
  } stmr_ctrl1_t;

  // ****************************
  // pin carrier
  // ****************************
  typedef struct packed {
    logic timer_out;
    logic timer_out_inv;
    logic timer_out_en;
  } stmr_pins_t;

endpackage

// >>> design/stmr_top.sv
/*
  standard timer core with apb register slave, one pclk domain.
  assumes synchronous pins and sub/high clock ticks given as one cycle pulses.
*/
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
module stmr_top import stmr_pkg::*; #(
  parameter bit LONG = 1'b1
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // clock sources and pins
  input  wire logic        fh_tick,
  input  wire logic        fsub_tick,
  input  wire logic        ext_clk_in,
  input  wire logic        capture_in,
  input  wire logic        radio_data_bit,
  output stmr_pins_t       pins,
  output logic             match_a_evt,
  output logic             match_p_evt
);

  // ****************************
  // registers
  // ****************************
  localparam int W = LONG ? 16 : 10;

  stmr_ctrl0_t ctrl0;
  stmr_ctrl1_t ctrl1;
  logic [7:0]  cmpp_long;
  logic [15:0] cmp_a_value;
  logic [15:0] count;
  logic [15:0] cap_value;
  logic [7:0]  byte_buf;
  logic        capture_src_sel;
  logic        on_q;
  logic        ext_q;
  logic        capsig_q;
  logic        out_q;
  logic        pulse_done;
  logic [5:0]  pre;
  logic [1:0]  pre4;
  logic [15:0] next_count;

  // ****************************
  // apb decode
  // ****************************
  wire acc   = psel & penable;
  wire wr    = acc & pwrite;
  // low byte latched at setup, with prdata, so both halves see one count
  wire rd_setup = psel & ~penable & ~pwrite;
  wire known = (paddr <= STMR_STAT_ADDR) && (paddr[1:0] == 2'b00);
  wire [15:0] cmask = 16'((32'h1 << W) - 32'h1);

  // ****************************
  // clock source
  // ****************************
  wire ext_rise = ext_clk_in & ~ext_q;
  wire ext_fall = ~ext_clk_in & ext_q;
  wire h16 = fh_tick && pre[3:0] == 4'(STMR_DIV_H16 - 1);
  wire h64 = fh_tick && pre == 6'(STMR_DIV_H64 - 1);
  logic tick_src;
  always_comb begin
    unique case (ctrl0.clk_sel)
      3'h0: tick_src = pre4 == 2'(STMR_DIV_SYS4 - 1);
      3'h1: tick_src = 1'b1;
      3'h2: tick_src = h16;
      3'h3: tick_src = h64;
      3'h4, 3'h5: tick_src = fsub_tick;
      3'h6: tick_src = ext_rise;
      default: tick_src = ext_fall;
    endcase
  end
  wire on_rise = ctrl0.counter_on & ~on_q;
  wire run     = ctrl0.counter_on & ~ctrl0.pause_ctl & ~on_rise;
  wire tick    = run & tick_src;

  // ****************************
  // comparators
  // ****************************
  wire [7:0] pfield = LONG ? cmpp_long : {5'h00, ctrl0.period_cmp_field};
  wire [7:0] ctop   = LONG ? count[15:8] : {5'h00, count[9:7]};
  wire p_zero  = pfield == 8'h00;
  wire at_max  = count == cmask;
  wire [15:0] cnt_inc = (count + 16'h0001) & cmask;
  wire [7:0]  inc_top = LONG ? cnt_inc[15:8] : {5'h00, cnt_inc[9:7]};
  // match taken as the counter enters the compare value
  wire p_hit = tick & (p_zero ? at_max : (inc_top == pfield && ctop != pfield));
  wire a_hit = tick & (cmp_a_value != 16'h0000) & (cnt_inc == cmp_a_value);
  wire ovf   = tick & at_max;
  stmr_mode_t mode;
  assign mode = stmr_mode_t'(ctrl1.op_mode_sel);
  wire clr_en  = mode == STMR_M_CMP || mode == STMR_M_TMR;
  // swapped pwm takes its period from compare a
  wire clr_by_a = clr_en ? ctrl1.clear_src_sel : (mode == STMR_M_PWM && ctrl1.duty_period_swap);
  wire clr_hw  = clr_by_a ? a_hit : (p_hit | ovf);
  wire a_evt   = a_hit;
  wire p_evt   = p_hit & ~(clr_en & ctrl1.clear_src_sel);

  always_comb begin
    if (on_rise) begin
      next_count = 16'h0000;
    end else if (clr_hw) begin
      next_count = 16'h0000;
    end else if (tick) begin
      next_count = cnt_inc;
    end else begin
      next_count = count;
    end
  end

  // ****************************
  // capture
  // ****************************
  wire capsig = (!LONG && capture_src_sel) ? radio_data_bit : capture_in;
  wire cr = capsig & ~capsig_q;
  wire cf = ~capsig & capsig_q;
  logic cap_hit;
  always_comb begin
    unique case (ctrl1.pin_func_sel)
      2'h0: cap_hit = cr;
      2'h1: cap_hit = cf;
      2'h2: cap_hit = cr | cf;
      default: cap_hit = 1'b0;
    endcase
  end
  wire cap_take = mode == STMR_M_CAP && ctrl0.counter_on && cap_hit;

  // ****************************
  // output pin
  // ****************************
  // duty taken from compare a unless swapped; period then follows clear
  wire [15:0] duty = ctrl1.duty_period_swap ? {pfield, 8'h00} : cmp_a_value;
  wire pwm_act = count < (duty & cmask);
  wire act = ctrl1.out_initial_level;
  logic next_out;
  always_comb begin
    next_out = out_q;
    if (on_rise) begin
      next_out = ctrl1.out_initial_level;
    end else if (mode == STMR_M_CMP && a_evt) begin
      unique case (ctrl1.pin_func_sel)
        2'h0: next_out = out_q;
        2'h1: next_out = 1'b0;
        2'h2: next_out = 1'b1;
        default: next_out = ~out_q;
      endcase
    end else if (mode == STMR_M_PWM) begin
      unique case (ctrl1.pin_func_sel)
        2'h0: next_out = ~act;
        2'h1: next_out = act;
        2'h2: next_out = ctrl0.counter_on ? (pwm_act ? act : ~act) : out_q;
        default: next_out = (ctrl0.counter_on & ~pulse_done) ? act : ~act;
      endcase
    end
  end
  wire pin_lvl = out_q ^ ctrl1.out_polarity;

  // ****************************
  // read mux
  // ****************************
  wire [15:0] ahi = cmp_a_value >> 8;
  wire [15:0] chi = count >> 8;
  wire [15:0] khi = cap_value >> 8;
  logic [7:0] rbyte;
  always_comb begin
    unique case (paddr)
      STMR_CTRL0_ADDR: rbyte = LONG ? {ctrl0[7:3], 3'h0} : ctrl0;
      STMR_CTRL1_ADDR: rbyte = ctrl1;
      STMR_CNTL_ADDR:  rbyte = byte_buf;
      STMR_CNTH_ADDR:  rbyte = chi[7:0];
      STMR_CMPAL_ADDR: rbyte = byte_buf;
      STMR_CMPAH_ADDR: rbyte = ahi[7:0];
      STMR_CMPP_ADDR:  rbyte = LONG ? cmpp_long : 8'h00;
      STMR_INSRC_ADDR: rbyte = {7'h00, capture_src_sel};
      STMR_CAPL_ADDR:  rbyte = byte_buf;
      STMR_CAPH_ADDR:  rbyte = khi[7:0];
      STMR_STAT_ADDR:  rbyte = {5'h00, pulse_done, on_q, out_q};
      default:         rbyte = 8'h00;
    endcase
  end

  // ****************************
  // sequential
  // ****************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= STMR_CTRL_RESET;
      ctrl1 <= STMR_CTRL_RESET;
      cmpp_long <= STMR_BYTE_RESET;
      capture_src_sel <= 1'b0;
      cmp_a_value <= 16'h0000;
      byte_buf <= STMR_BYTE_RESET;
    end else begin
      if (wr && paddr == STMR_CTRL0_ADDR) ctrl0 <= pwdata[7:0];
      if (wr && paddr == STMR_CTRL1_ADDR) ctrl1 <= pwdata[7:0];
      if (wr && paddr == STMR_CMPP_ADDR && LONG) cmpp_long <= pwdata[7:0];
      if (wr && paddr == STMR_INSRC_ADDR) capture_src_sel <= pwdata[0];
      if (wr && paddr == STMR_CMPAL_ADDR) byte_buf <= pwdata[7:0];
      if (wr && paddr == STMR_CMPAH_ADDR) begin
        cmp_a_value <= {pwdata[7:0], byte_buf} & cmask;
      end
      if (rd_setup && paddr == STMR_CNTH_ADDR) byte_buf <= count[7:0];
      if (rd_setup && paddr == STMR_CMPAH_ADDR) byte_buf <= cmp_a_value[7:0];
      if (rd_setup && paddr == STMR_CAPH_ADDR) byte_buf <= cap_value[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
      cap_value <= 16'h0000;
      on_q <= 1'b0;
      ext_q <= 1'b0;
      capsig_q <= 1'b0;
      out_q <= 1'b0;
      pulse_done <= 1'b0;
      pre <= STMR_PRE_RESET;
      pre4 <= 2'h0;
    end else begin
      count <= next_count;
      on_q <= ctrl0.counter_on;
      ext_q <= ext_clk_in;
      capsig_q <= capsig;
      out_q <= next_out;
      pre4 <= pre4 + 2'h1;
      if (fh_tick) pre <= pre + 6'h01;
      if (cap_take) cap_value <= count;
      if (on_rise) pulse_done <= 1'b0;
      else if (mode == STMR_M_PWM && (a_evt | clr_hw)) pulse_done <= 1'b1;
    end
  end

  // ****************************
  // registered outputs
  // ****************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pins <= 3'b010;
      match_a_evt <= 1'b0;
      match_p_evt <= 1'b0;
    end else begin
      // no wait state: pready and read data are registered from the setup cycle
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      prdata <= {24'h000000, rbyte};
      pins.timer_out <= pin_lvl;
      pins.timer_out_inv <= ~pin_lvl;
      pins.timer_out_en <= mode != STMR_M_TMR && mode != STMR_M_CAP;
      match_a_evt <= a_evt;
      match_p_evt <= p_evt;
    end
  end

endmodule // stmr_top

// >>> verif/stmr_sva.sv
/*
  port checker of the standard timer, bound to stmr_top.
  assumes one pclk domain and byte registers reached over apb.
*/
`timescale 1ns/1ns
module stmr_sva import stmr_pkg::*; (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // timer outputs
  input wire stmr_pins_t  pins,
  input wire logic        match_a_evt,
  input wire logic        match_p_evt
);
  logic [7:0] sh0;
  logic [7:0] sh1;
  wire        wr_done = psel && penable && pready && pwrite;
  // shadow of both control bytes, as software last wrote them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh0 <= 8'h00;
      sh1 <= 8'h00;
    end else if (wr_done && paddr == STMR_CTRL0_ADDR) begin
      sh0 <= pwdata[7:0];
    end else if (wr_done && paddr == STMR_CTRL1_ADDR) begin
      sh1 <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_inv_mirror: assert property (pins.timer_out_inv == !pins.timer_out)
    else $error("inverted pin differs from output");
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_unmapped_err: assert property (pready && !pwrite && paddr > STMR_STAT_ADDR
    |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  chk_on_init: assert property (wr_done && paddr == STMR_CTRL0_ADDR && pwdata[3] && !sh0[3]
    && sh1[7:6] == 2'h0 |-> ##[1:3] pins.timer_out == (sh1[3] ^ sh1[2]))
    else $error("pin not at initial level after switch on");
  chk_tmr_release: assert property (wr_done && paddr == STMR_CTRL1_ADDR
    && pwdata[7:6] == 2'h3 |-> ##3 !pins.timer_out_en) else $error("pin kept in timer mode");
  chk_p_quiet: assert property ((sh1[0] && sh1[7:6] == 2'h0)[*3] |-> !match_p_evt)
    else $error("p match with a clearing");
  chk_a_toggle: assert property (match_a_evt && sh1[7:4] == 4'h3 && sh0[3]
    |-> ##[0:2] $changed(pins.timer_out)) else $error("no toggle on a match");
  cover property (match_a_evt);
  cover property (match_p_evt);
  cover property (pslverr);
endmodule // stmr_sva

bind stmr_top stmr_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pins(pins), .match_a_evt(match_a_evt), .match_p_evt(match_p_evt));

// >>> verif/stmr_partner.sv
/*
  far side of the timer pins: clock ticks, external clock, capture lines.
  assumes one pclk domain; the external clock moves only while run is high.
*/
`timescale 1ns/1ns
module stmr_partner (
  // control
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  // pins
  output logic      fh_tick,
  output logic      fsub_tick,
  output logic      ext_clk_in,
  output logic      capture_in,
  output logic      radio_data_bit
);
  logic [2:0] phase;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 3'h0;
      ext_clk_in <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      if (run && phase[1:0] == 2'h3) begin
        ext_clk_in <= !ext_clk_in;
      end
    end
  end
  // high clock as fast as pclk, sub clock one tick in eight
  assign fh_tick = presetn;
  assign fsub_tick = phase == 3'h7;
  assign capture_in = run & phase[2];
  assign radio_data_bit = !capture_in;
endmodule // stmr_partner

// >>> verif/tb.sv
/*
  self-checking bench of the long timer through apb byte registers.
  assumes the partner model on the pins and the checker bound in.
*/
`timescale 1ns/1ns
module tb import stmr_pkg::*;;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, fh, fsub, eclk, cap, rad, m_a, m_p, err;
  logic        run = 1'b0;
  stmr_pins_t  pins;
  int          n_mismatch = 0, comparisons = 0, n;
  logic [15:0] v1, v2;
  logic [7:0]  d;
  // cmp x4, capture, pwm inactive, pwm active, timer
  localparam logic [7:0] MODES [8] = '{8'h09, 8'h19, 8'h29, 8'h39, 8'h49, 8'h88, 8'h98, 8'hc9};
  localparam logic [7:0] EN_EXP = 8'h6f;
  localparam logic [7:0] OUT_EXP = 8'h45;
  localparam int DIVS [8] = '{4, 1, 16, 64, 8, 8, 8, 8};
  stmr_top #(.LONG(1'b1)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fh_tick(fh), .fsub_tick(fsub), .ext_clk_in(eclk), .capture_in(cap),
    .radio_data_bit(rad), .pins(pins), .match_a_evt(m_a), .match_p_evt(m_p));
  stmr_partner u_far (.pclk(pclk), .presetn(presetn), .run(run), .fh_tick(fh),
    .fsub_tick(fsub), .ext_clk_in(eclk), .capture_in(cap), .radio_data_bit(rad));
  initial begin
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; waits on pready, the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    bus(1'b1, a, wd, d);
  endtask
  // high byte first, so the low byte comes from the latched buffer
  task automatic rd16(input logic [7:0] ah, output logic [15:0] v);
    bus(1'b0, ah, 8'h00, v[15:8]);
    bus(1'b0, ah - 8'h04, 8'h00, v[7:0]);
  endtask
  task automatic wait_p(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (m_p !== 1'b1);
  endtask
  task automatic end_sim;
    $display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 30000);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 8'(4 * i), 8'h00, d);
      chk("reset value", {8'h00, d}, 16'h0000);
    end
    wr(STMR_CMPAL_ADDR, 8'h34);
    rd16(STMR_CMPAH_ADDR, v1);
    chk("cmpa low held", v1, 16'h0000);
    // the high read refilled the shared buffer, so load the low byte again
    wr(STMR_CMPAL_ADDR, 8'h34);
    wr(STMR_CMPAH_ADDR, 8'h12);
    rd16(STMR_CMPAH_ADDR, v1);
    chk("cmpa pair", v1, 16'h1234);
    bus(1'b0, 8'h3c, 8'h00, d);
    chk("unmapped", {7'h00, err, d}, 16'h0100);
    $display("test byte access done");
    wr(STMR_CTRL1_ADDR, 8'hc0);
    run <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(STMR_CTRL0_ADDR, 8'(s * 16 + 8));
      repeat (256) @(posedge pclk);
      wr(STMR_CTRL0_ADDR, 8'(s * 16));
      rd16(STMR_CNTH_ADDR, v1);
      n = 256 / DIVS[s];
      chk("clk_sel count", 16'(v1 + 3 > n && v1 < n + 3), 16'h0001);
    end
    run <= 1'b0;
    $display("test clock select done");
    wr(STMR_CTRL0_ADDR, 8'h18);
    repeat (40) @(posedge pclk);
    wr(STMR_CTRL0_ADDR, 8'h98);
    rd16(STMR_CNTH_ADDR, v1);
    repeat (20) @(posedge pclk);
    rd16(STMR_CNTH_ADDR, v2);
    chk("paused count", v2, v1);
    wr(STMR_CTRL0_ADDR, 8'h18);
    rd16(STMR_CNTH_ADDR, v2);
    chk("resumed count", 16'(v2 > v1 && v2 < v1 + 16), 16'h0001);
    wr(STMR_CTRL0_ADDR, 8'h10);
    rd16(STMR_CNTH_ADDR, v1);
    repeat (20) @(posedge pclk);
    rd16(STMR_CNTH_ADDR, v2);
    chk("off count", v2, v1);
    wr(STMR_CTRL0_ADDR, 8'h18);
    rd16(STMR_CNTH_ADDR, v2);
    chk("restart count", 16'(v2 < 16'h0010), 16'h0001);
    $display("test pause and on done");
    wr(STMR_CMPAL_ADDR, 8'h10);
    wr(STMR_CMPAH_ADDR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(STMR_CTRL0_ADDR, 8'h10);
      wr(STMR_CTRL1_ADDR, MODES[i]);
      wr(STMR_CTRL0_ADDR, 8'h18);
      repeat (24) @(posedge pclk);
      chk("pin enable", {15'h0, pins.timer_out_en}, {15'h0, EN_EXP[i]});
      if (EN_EXP[i]) chk("pin level", {15'h0, pins.timer_out}, {15'h0, OUT_EXP[i]});
    end
    $display("test pin modes done");
    for (int p = 1; p < 3; p++) begin
      wr(STMR_CTRL0_ADDR, 8'h10);
      wr(STMR_CTRL1_ADDR, 8'h00);
      wr(STMR_CMPP_ADDR, 8'(p));
      wr(STMR_CTRL0_ADDR, 8'h18);
      wait_p(n);
      wait_p(n);
      chk("p period", 16'(n), 16'(256 * p));
    end
    $display("test p period done");
    wr(STMR_CTRL0_ADDR, 8'h10);
    wr(STMR_CTRL1_ADDR, 8'hbc);
    wr(STMR_CTRL0_ADDR, 8'h18);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (m_a !== 1'b1);
    chk("a match delay", 16'(n), 16'h0012);
    chk("pulse active", {15'h0, pins.timer_out}, 16'h0000);
    repeat (4) @(posedge pclk);
    chk("pulse ended", {15'h0, pins.timer_out}, 16'h0001);
    bus(1'b0, STMR_STAT_ADDR, 8'h00, d);
    chk("pulse status", {8'h00, d}, 16'h0006);
    $display("test single pulse done");
    wr(STMR_CTRL0_ADDR, 8'h10);
    wr(STMR_CTRL1_ADDR, 8'h40);
    wr(STMR_CTRL0_ADDR, 8'h18);
    run <= 1'b1;
    repeat (40) @(posedge pclk);
    wr(STMR_CTRL0_ADDR, 8'h10);
    run <= 1'b0;
    rd16(STMR_CAPH_ADDR, v1);
    rd16(STMR_CNTH_ADDR, v2);
    chk("capture rising", 16'(v1 != 16'h0000 && v2 - v1 < 16'h000c), 16'h0001);
    wr(STMR_CTRL1_ADDR, 8'h70);
    wr(STMR_CTRL0_ADDR, 8'h18);
    run <= 1'b1;
    repeat (40) @(posedge pclk);
    wr(STMR_CTRL0_ADDR, 8'h10);
    run <= 1'b0;
    rd16(STMR_CAPH_ADDR, v2);
    chk("capture disabled", v2, v1);
    $display("test capture done");
    end_sim();
  end
endmodule // tb
